//--- dv/mss_peer.sv
`timescale 1ns/10ps
module mss_peer (
  // clock
  input wire logic clk,
  // line polarity and readiness
  input wire logic pol,
  input wire logic peer_rdy,
  // strong drive onto the line
  output logic peer_oe,
  output logic peer_out
);
  // a member that is not ready pins the line inactive
  always_ff @(posedge clk) begin
    peer_oe <= !peer_rdy;
  end
  assign peer_out = ~pol;
endmodule : mss_peer

//--- dv/tb_masterless_start_sync.sv
`timescale 1ns/10ps
module tb_masterless_start_sync;
  logic clk = 0, reset = 1, busy_en = 0, pol = 1, start_int = 0, peer_rdy = 0;
  logic [7:0] hold_cycles = 8'h00;
  logic start_in, start_out, start_oe, start_weak, all_ready, busy, peer_oe, peer_out;
  int n_mismatch = 0, checks_done = 0;
  always #25 clk = ~clk;
  // strong drivers win, the weak pull only counts when nobody drives hard
  assign start_in = start_oe ? start_out : peer_oe ? peer_out : start_weak ? start_out : ~pol;
  mss_start_sync uut (.clk(clk), .reset(reset), .busy_en(busy_en),
    .start_pol_high(pol), .hold_cycles(hold_cycles), .start_int(start_int),
    .start_in(start_in), .start_out(start_out), .start_oe(start_oe),
    .start_weak(start_weak), .all_ready(all_ready), .busy(busy));
  mss_peer peer (.clk(clk), .pol(pol), .peer_rdy(peer_rdy), .peer_oe(peer_oe),
    .peer_out(peer_out));
  ////////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) begin
      @(posedge clk);
      #5;
    end
  endtask : cyc
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  task t_idle;
    start_int = 1;
    cyc(1);
    start_int = 0;
    cyc(1);
    chk("weak", start_weak, 8'h00);
    chk("oe", start_oe, 8'h00);
    $display("idle done");
  endtask : t_idle
  task t_busy;
    busy_en = 1;
    cyc(2);
    chk("busy", busy, 8'h01);
    chk("oe", start_oe, 8'h01);
    chk("out", start_out, {7'h00, ~pol});
    $display("busy done");
  endtask : t_busy
  task t_sync(input logic [7:0] h);
    int n;
    hold_cycles = h;
    start_int = 1;
    cyc(1);
    start_int = 0;
    chk("weak", start_weak, 8'h01);
    chk("oe", start_oe, 8'h00);
    chk("out", start_out, {7'h00, pol});
    cyc(8);
    chk("held", start_oe | all_ready, 8'h00);
    peer_rdy = 1;
    n = 0;
    while (all_ready !== 1'b1 && n < 10) begin
      n++;
      cyc(1);
    end
    chk("ready", all_ready, 8'h01);
    n = 0;
    while (start_oe === 1'b1 && start_out === pol && n < 300) begin
      n++;
      cyc(1);
    end
    chk("hold", n[7:0], h + 8'h01);
    chk("rebusy", {busy, start_oe, start_out}, {5'h00, 2'b11, ~pol});
    peer_rdy = 0;
    $display("sync done");
  endtask : t_sync
  // release from busy, then drop the enable before the line goes active
  task t_disable;
    start_int = 1;
    cyc(1);
    start_int = 0;
    busy_en = 0;
    chk("weak", start_weak, 8'h01);
    cyc(1);
    chk("off", {start_weak, start_oe, busy}, 8'h00);
    peer_rdy = 1;
    cyc(6);
    chk("no ready", all_ready | start_oe, 8'h00);
    peer_rdy = 0;
    $display("disable done");
  endtask : t_disable
  // second reset in mid-run while busy, with the polarity flipped under it
  task t_pol_low;
    busy_en = 1;
    cyc(2);
    reset = 1;
    pol = 0;
    busy_en = 0;
    cyc(2);
    chk("reset", {start_out, start_oe, start_weak, busy, all_ready}, 8'h00);
    reset = 0;
    $display("reset done");
  endtask : t_pol_low
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    reset = 0;
    t_idle();
    t_busy();
    t_sync(8'h00);
    t_sync(8'h03);
    t_disable();
    t_pol_low();
    t_busy();
    t_sync(8'h01);
    test_done();
  end
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule : tb_masterless_start_sync

//--- rtl/mss_map.svh
`ifndef MSS_MAP_SVH
`define MSS_MAP_SVH
`define MSS_TRIG_SETUP_OFS 8'h02
`define MSS_HOLD_W 8
`define MSS_HOLD_ZERO 8'h00
`define MSS_HOLD_ONE 8'h01
// two samples still ride in the pin synchroniser after the release
`define MSS_SYNC_SETTLE 8'h02
`define MSS_RUN_ZERO 9'h000
`define MSS_RUN_ONE 9'h001
`endif

//--- rtl/mss_pkg.sv
package mss_pkg;
  typedef enum logic [1:0] {
    MSS_IDLE = 2'b00,
    MSS_BUSY = 2'b01,
    MSS_WAIT = 2'b11,
    MSS_HOLD = 2'b10
  } mss_state_e;
endpackage : mss_pkg

//--- rtl/mss_start_sync.sv
`timescale 1ns/10ps
`include "mss_map.svh"
module mss_start_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // configuration
  input wire logic busy_en,
  input wire logic start_pol_high,
  input wire logic [`MSS_HOLD_W-1:0] hold_cycles,
  // internal start event from the start timer
  input wire logic start_int,
  // shared start line
  input wire logic start_in,
  output logic start_out,
  output logic start_oe,
  output logic start_weak,
  // status
  output logic all_ready,
  output logic busy
);
  mss_pkg::mss_state_e state_reg, state_next;
  logic [`MSS_HOLD_W-1:0] cnt_reg, cnt_next;
  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic weak_reg, weak_next;
  logic rdy_reg, rdy_next;
  logic busy_reg, busy_next;
  logic line_s;
  logic line_act;

  ////////////////////////////////////////////////////////////////////////////
  // level compare against the programmed polarity; the pin decode and the
  // checks below must agree on it
  function automatic logic line_is_active(input logic lvl, input logic pol_high);
    line_is_active = (lvl == pol_high);
  endfunction : line_is_active

  function automatic logic [`MSS_HOLD_W-1:0] count_down(input logic [`MSS_HOLD_W-1:0] v);
    count_down = v - `MSS_HOLD_ONE;
  endfunction : count_down

  ////////////////////////////////////////////////////////////////////////////
  // pin enters through two flops before anything looks at it
  mss_sync2 u_sync (
    .clk(clk),
    .reset(reset),
    .d(start_in),
    .q(line_s)
  );

  assign line_act = line_is_active(line_s, start_pol_high);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rdy_next = 1'b0;
    case (state_reg)
      mss_pkg::MSS_IDLE: begin
        if (busy_en) state_next = mss_pkg::MSS_BUSY;
      end
      mss_pkg::MSS_BUSY: begin
        if (!busy_en) state_next = mss_pkg::MSS_IDLE;
        else if (start_int) begin
          // the synchroniser still holds the line from before the release
          state_next = mss_pkg::MSS_WAIT;
          cnt_next = `MSS_SYNC_SETTLE;
        end
      end
      mss_pkg::MSS_WAIT: begin
        if (!busy_en) begin
          state_next = mss_pkg::MSS_IDLE;
        end else if (cnt_reg != `MSS_HOLD_ZERO) begin
          // samples taken before our own release must not count as ready
          cnt_next = count_down(cnt_reg);
        end else if (line_act) begin
          // line only reads active once every member let go
          state_next = mss_pkg::MSS_HOLD;
          cnt_next = hold_cycles;
          rdy_next = 1'b1;
        end
      end
      mss_pkg::MSS_HOLD: begin
        // zero extension still gives one strong active cycle
        if (cnt_reg == `MSS_HOLD_ZERO) state_next = mss_pkg::MSS_BUSY;
        else cnt_next = count_down(cnt_reg);
      end
      default: state_next = mss_pkg::MSS_IDLE;
    endcase
  end

  // pin outputs registered from the next state, so they follow state at once
  always_comb begin
    oe_next = 1'b0;
    weak_next = 1'b0;
    out_next = ~start_pol_high;
    busy_next = 1'b0;
    case (state_next)
      mss_pkg::MSS_BUSY: begin
        oe_next = 1'b1;
        busy_next = 1'b1;
      end
      mss_pkg::MSS_WAIT: begin
        weak_next = 1'b1;
        out_next = start_pol_high;
      end
      mss_pkg::MSS_HOLD: begin
        oe_next = 1'b1;
        out_next = start_pol_high;
      end
      default: begin
        oe_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= mss_pkg::MSS_IDLE;
      cnt_reg <= `MSS_HOLD_ZERO;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      weak_reg <= 1'b0;
      rdy_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      weak_reg <= weak_next;
      rdy_reg <= rdy_next;
      busy_reg <= busy_next;
    end
  end

  assign start_out = out_reg;
  assign start_oe = oe_reg;
  assign start_weak = weak_reg;
  assign all_ready = rdy_reg;
  assign busy = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checker helpers: length of each strong active burst on the pin, and the
  // length that the extension count loaded at its start calls for
  logic [`MSS_HOLD_W:0] run_reg, run_next;
  logic [`MSS_HOLD_W:0] want_reg, want_next;
  logic strong_act;

  assign strong_act = start_oe && line_is_active(start_out, start_pol_high);

  always_comb begin
    run_next = `MSS_RUN_ZERO;
    want_next = want_reg;
    if (strong_act) begin
      run_next = run_reg + `MSS_RUN_ONE;
    end
    if (all_ready) begin
      want_next = {1'b0, cnt_reg} + `MSS_RUN_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      run_reg <= `MSS_RUN_ZERO;
      want_reg <= `MSS_RUN_ZERO;
    end else begin
      run_reg <= run_next;
      want_reg <= want_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_IDLE_WHEN_DISABLED: assert property (@(posedge clk) disable iff (reset)
    !busy_en && state_reg != mss_pkg::MSS_HOLD |=> !start_oe && !start_weak)
    else $error("line driven while sync disabled");
  AST_BUSY_INACTIVE: assert property (@(posedge clk) disable iff (reset)
    busy |-> start_oe && (start_out == ~start_pol_high) && !start_weak)
    else $error("busy without strong inactive drive");
  AST_START_RELEASES: assert property (@(posedge clk) disable iff (reset)
    busy && busy_en && start_int |=> !start_oe && start_weak && start_out == start_pol_high)
    else $error("start signal did not release line");
  AST_READY_HOLD: assert property (@(posedge clk) disable iff (reset)
    all_ready |-> start_oe && start_out == start_pol_high && !start_weak)
    else $error("all ready without strong active drive");
  AST_HOLD_LEN: assert property (@(posedge clk) disable iff (reset)
    all_ready && $stable(start_pol_high) && cnt_reg == `MSS_HOLD_ZERO |=> busy)
    else $error("zero extension not a single cycle");
  AST_BACK_TO_BUSY: assert property (@(posedge clk) disable iff (reset)
    state_reg == mss_pkg::MSS_HOLD && cnt_reg == `MSS_HOLD_ZERO |=> busy && start_oe)
    else $error("no return to busy after hold");
  AST_WAIT_NO_STRONG: assert property (@(posedge clk) disable iff (reset)
    start_weak |-> !start_oe)
    else $error("weak and strong drive together");
  AST_RDY_CAUSE: assert property (@(posedge clk) disable iff (reset)
    all_ready |-> $past(state_reg) == mss_pkg::MSS_WAIT && $past(line_act))
    else $error("ready without active line");

  // a member just back from its burst still sees its own active level in
  // the synchroniser; readiness may only count after that has flushed out
  AST_NO_STALE_READY: assert property (@(posedge clk) disable iff (reset)
    $rose(start_weak) |=> !all_ready ##1 !all_ready)
    else $error("ready taken from a stale line sample");
  AST_HOLD_STRONG: assert property (@(posedge clk) disable iff (reset)
    state_reg == mss_pkg::MSS_HOLD
    |-> start_oe && !start_weak && line_is_active(start_out, start_pol_high))
    else $error("hold state without strong active drive");
  AST_LOAD_HOLD: assert property (@(posedge clk) disable iff (reset)
    all_ready |-> cnt_reg == $past(hold_cycles))
    else $error("extension count not taken at ready");
  AST_WEAK_ACTIVE: assert property (@(posedge clk) disable iff (reset)
    start_weak |-> line_is_active(start_out, start_pol_high))
    else $error("weak drive not at active level");
  AST_START_IGNORED: assert property (@(posedge clk) disable iff (reset)
    start_int && !busy && !start_weak |=> !start_weak)
    else $error("start signal acted on outside busy");
  AST_BURST_LEN: assert property (@(posedge clk) disable iff (reset)
    $rose(busy) && $past(start_oe) |-> run_reg == want_reg)
    else $error("strong active burst of wrong length");

  COV_RELEASE: cover property (@(posedge clk) disable iff (reset) busy ##1 start_weak);
  COV_ALL_READY: cover property (@(posedge clk) disable iff (reset) start_weak ##1 all_ready);
  COV_FULL: cover property (@(posedge clk) disable iff (reset)
    all_ready ##[1:300] busy);
  COV_DISABLE_WAIT: cover property (@(posedge clk) disable iff (reset)
    (start_weak && !busy_en) ##1 !start_weak);
  COV_LONG_HOLD: cover property (@(posedge clk) disable iff (reset)
    all_ready ##1 (start_oe && !busy));
endmodule : mss_start_sync

//--- rtl/mss_sync2.sv
`timescale 1ns/10ps
module mss_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // level in and out
  input wire logic d,
  output logic q
);
  logic s1_reg;
  logic s1_next;
  logic q_reg;
  logic q_next;

  always_comb begin
    s1_next = d;
    q_next = s1_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule : mss_sync2
